// ==== amr_gain_dec.sv ====
// Decodes a three-bit mixer gain code into a signed gain in dB.
// Assumes the user registers the result; purely combinational.
`timescale 1ns/1ps
module amr_gain_dec (
  // Code in, gain out
  amr_gain_if.dec g
);

  logic signed [5:0] lin_db;

  always_comb begin
    lin_db = amr_pkg::GAIN_BASE_DB
      + $signed({3'h0, g.code}) * amr_pkg::GAIN_STEP_DB;
    g.muted = (g.code == amr_pkg::GAIN_MUTE);
    if (g.code == amr_pkg::GAIN_MUTE) begin
      g.db = amr_pkg::GAIN_MUTE_DB;
    end else if (g.boost && g.code == amr_pkg::GAIN_MAX) begin
      // Boost only lifts the top code
      g.db = amr_pkg::GAIN_BOOST_DB;
    end else begin
      g.db = lin_db[4:0];
    end
  end

endmodule : amr_gain_dec

// ==== amr_gain_if.sv ====
// Carries a gain code to its decoder and the decoded gain back.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface amr_gain_if;
  logic [2:0] code;
  logic boost;
  logic signed [4:0] db;
  logic muted;

  modport dec (
    input code,
    input boost,
    output db,
    output muted
  );

  modport user (
    output code,
    output boost,
    input db,
    input muted
  );
endinterface : amr_gain_if

// ==== amr_pkg.sv ====
// Constants for the audio mixer routing register bank.
// Assumes a 32-bit APB with word-aligned registers.
package amr_pkg;

  // Bus widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_RIN_DIRECT = 10'h02C;
  localparam logic [9:0] IDX_LOUT_ROUTE = 10'h02D;
  localparam logic [9:0] IDX_ROUT_ROUTE = 10'h02E;
  localparam logic [9:0] IDX_MIX_CTRL = 10'h040;
  localparam logic [9:0] IDX_MIX_STATUS = 10'h041;

  // Reset values
  localparam logic [15:0] RST_RIN_DIRECT = 16'h0000;
  localparam logic [15:0] RST_LOUT_ROUTE = 16'h0000;
  localparam logic [15:0] RST_ROUT_ROUTE = 16'h0000;
  localparam logic [15:0] RST_MIX_CTRL = 16'h0000;

  // Writable bits of each register
  localparam logic [15:0] MSK_RIN_DIRECT = 16'h01C7;
  localparam logic [15:0] MSK_ROUTE = 16'h01FF;
  localparam logic [15:0] MSK_MIX_CTRL = 16'h0003;

  // Field positions, input mixer direct gain register
  localparam int unsigned F_BYP_GAIN_LSB = 6;
  localparam int unsigned F_BYP_GAIN_MSB = 8;
  localparam int unsigned F_RXV_GAIN_LSB = 0;
  localparam int unsigned F_RXV_GAIN_MSB = 2;

  // Field positions, output mixer routing registers
  localparam int unsigned F_PHONES_SEL = 8;
  localparam int unsigned F_CROSS_MIX = 7;
  localparam int unsigned F_SAME_MIX = 6;
  localparam int unsigned F_OTHER_L2N = 5;
  localparam int unsigned F_SAME_L2N = 4;
  localparam int unsigned F_OTHER_AMP1 = 3;
  localparam int unsigned F_SAME_AMP1 = 2;
  localparam int unsigned F_SAME_L2P = 1;
  localparam int unsigned F_DAC = 0;

  // Field positions, control and status
  localparam int unsigned F_BOOST = 0;
  localparam int unsigned F_MIDRAIL_EN = 1;
  localparam int unsigned F_ST_NEEDED = 0;
  localparam int unsigned F_ST_MISSING = 1;

  // Gain code arithmetic, in dB
  localparam logic [2:0] GAIN_MUTE = 3'h0;
  localparam logic [2:0] GAIN_MAX = 3'h7;
  localparam logic signed [5:0] GAIN_BASE_DB = -6'sd15;
  localparam logic signed [5:0] GAIN_STEP_DB = 6'sd3;
  localparam logic signed [4:0] GAIN_BOOST_DB = 5'sd15;
  localparam logic signed [4:0] GAIN_MUTE_DB = 5'sd0;

  // Number of decoded gain fields
  localparam int unsigned NUM_GAIN = 2;
  localparam int unsigned GI_BYPASS = 0;
  localparam int unsigned GI_RECEIVE_VOICE_INPUT = 1;

  // Bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } amr_state_t;

endpackage : amr_pkg

// ==== amr_regs.sv ====
// Mixer routing and gain register bank behind an APB slave.
// Assumes a same-clock APB master; no pins cross a clock domain.
//
// Contract
// - Bits 8:6 of 0x2C: bypass gain, reset mute
// - Boost makes bypass code 111 mean +15dB
// - Bits 2:0 of 0x2C: voice gain, reset mute
// - 0x2D bit 8 picks left phones source
// - 0x2D bits 7,6 route input mixers leftward
// - 0x2D bits 5,4,1 route second line inputs
// - 0x2D bits 3,2 route first amplifiers
// - 0x2D bit 0 routes left DAC
// - 0x2E bit 8 picks right phones source
// - 0x2E bits 7,6 route input mixers rightward
// - 0x2E bits 5,4,1 route second line inputs
// - 0x2E bits 3,2 route first amplifiers
// - 0x2E bit 0 routes right DAC
`timescale 1ns/1ps
module amr_regs (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Right input mixer gains and midrail buffer enable
  output logic [2:0] right_bypass_gain,
  output logic [2:0] rx_voice_right_gain,
  output logic right_bypass_boost,
  output logic midrail_buffer_enable,
  // Decoded gains
  output logic signed [4:0] right_bypass_db,
  output logic right_bypass_muted,
  output logic signed [4:0] rx_voice_right_db,
  output logic rx_voice_right_muted,
  // Left output mixer routing
  output logic left_phones_source_sel,
  output logic rin_mix_to_lout_mix_on,
  output logic lin_mix_to_lout_mix_on,
  output logic r_line2_neg_to_lout_on,
  output logic l_line2_neg_to_lout_on,
  output logic r_amp1_to_lout_on,
  output logic l_amp1_to_lout_on,
  output logic l_line2_pos_to_lout_on,
  output logic left_dac_to_lout_on,
  // Right output mixer routing
  output logic right_phones_source_sel,
  output logic lin_mix_to_rout_mix_on,
  output logic rin_mix_to_rout_mix_on,
  output logic l_line2_neg_to_rout_on,
  output logic r_line2_neg_to_rout_on,
  output logic l_amp1_to_rout_on,
  output logic r_amp1_to_rout_on,
  output logic r_line2_pos_to_rout_on,
  output logic right_dac_to_rout_on,
  // Midrail buffer status
  output logic midrail_needed,
  output logic midrail_missing
);

  amr_pkg::amr_state_t state_r;
  logic [15:0] rin_direct_r;
  logic [15:0] lout_route_r;
  logic [15:0] rout_route_r;
  logic [15:0] mix_ctrl_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic signed [4:0] byp_db_r;
  logic byp_muted_r;
  logic signed [4:0] rxv_db_r;
  logic rxv_muted_r;
  logic needed_r;
  logic missing_r;

  logic [9:0] widx;
  logic setup;
  logic wr_done;
  logic hit;
  logic [15:0] wbits;
  logic [15:0] wen;
  logic [31:0] rd_nxt;
  logic needed_nxt;
  logic [15:0] status_w;

  // Bus decode
  assign widx = paddr[11:2];
  assign setup = psel && !penable && state_r == amr_pkg::ST_IDLE;
  assign wr_done = psel && penable && pready_r && pwrite && !pslverr_r;
  assign wbits = pwdata[15:0];
  assign wen = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    hit = 1'b1;
    case (widx)
      amr_pkg::IDX_RIN_DIRECT: rd_nxt = {16'h0000, rin_direct_r};
      amr_pkg::IDX_LOUT_ROUTE: rd_nxt = {16'h0000, lout_route_r};
      amr_pkg::IDX_ROUT_ROUTE: rd_nxt = {16'h0000, rout_route_r};
      amr_pkg::IDX_MIX_CTRL: rd_nxt = {16'h0000, mix_ctrl_r};
      amr_pkg::IDX_MIX_STATUS: rd_nxt = {16'h0000, status_w};
      default: begin
        rd_nxt = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
  end

  // No wait state: pready rises in the first access cycle, with prdata and pready straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= amr_pkg::ST_IDLE;
    end else if (pclk_en) begin
      case (state_r)
        amr_pkg::ST_IDLE: begin
          if (setup) begin
            state_r <= amr_pkg::ST_ACK;
          end
        end
        amr_pkg::ST_ACK: begin
          if (psel && penable) begin
            state_r <= amr_pkg::ST_IDLE;
          end
        end
        default: state_r <= amr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (pclk_en) begin
      if (setup) begin
        pready_r <= 1'b1;
        pslverr_r <= !hit;
        prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      end else if (psel && penable && pready_r) begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // Only mapped fields take write data; the rest stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rin_direct_r <= amr_pkg::RST_RIN_DIRECT;
    end else if (pclk_en && wr_done
                 && widx == amr_pkg::IDX_RIN_DIRECT) begin
      rin_direct_r <= (rin_direct_r & ~wen)
        | (wbits & wen & amr_pkg::MSK_RIN_DIRECT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lout_route_r <= amr_pkg::RST_LOUT_ROUTE;
    end else if (pclk_en && wr_done
                 && widx == amr_pkg::IDX_LOUT_ROUTE) begin
      lout_route_r <= (lout_route_r & ~wen)
        | (wbits & wen & amr_pkg::MSK_ROUTE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rout_route_r <= amr_pkg::RST_ROUT_ROUTE;
    end else if (pclk_en && wr_done
                 && widx == amr_pkg::IDX_ROUT_ROUTE) begin
      rout_route_r <= (rout_route_r & ~wen)
        | (wbits & wen & amr_pkg::MSK_ROUTE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_ctrl_r <= amr_pkg::RST_MIX_CTRL;
    end else if (pclk_en && wr_done
                 && widx == amr_pkg::IDX_MIX_CTRL) begin
      mix_ctrl_r <= (mix_ctrl_r & ~wen)
        | (wbits & wen & amr_pkg::MSK_MIX_CTRL);
    end
  end

  // Gain decoders, one per three-bit gain field
  amr_gain_if gif [amr_pkg::NUM_GAIN] ();

  for (genvar gi = 0; gi < amr_pkg::NUM_GAIN; gi++) begin : g_dec
    if (gi == amr_pkg::GI_BYPASS) begin : g_byp
      assign gif[gi].code = rin_direct_r[amr_pkg::F_BYP_GAIN_MSB:
                                         amr_pkg::F_BYP_GAIN_LSB];
      assign gif[gi].boost = mix_ctrl_r[amr_pkg::F_BOOST];
    end else begin : g_rxv
      assign gif[gi].code = rin_direct_r[amr_pkg::F_RXV_GAIN_MSB:
                                         amr_pkg::F_RXV_GAIN_LSB];
      // Voice path has no boost option
      assign gif[gi].boost = 1'b0;
    end
    amr_gain_dec u_dec (
      .g(gif[gi])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byp_db_r <= amr_pkg::GAIN_MUTE_DB;
      byp_muted_r <= 1'b1;
      rxv_db_r <= amr_pkg::GAIN_MUTE_DB;
      rxv_muted_r <= 1'b1;
    end else if (pclk_en) begin
      byp_db_r <= gif[amr_pkg::GI_BYPASS].db;
      byp_muted_r <= gif[amr_pkg::GI_BYPASS].muted;
      rxv_db_r <= gif[amr_pkg::GI_RECEIVE_VOICE_INPUT].db;
      rxv_muted_r <= gif[amr_pkg::GI_RECEIVE_VOICE_INPUT].muted;
    end
  end

  // Software owns the buffer enable; the block only flags a gap
  always_comb begin
    needed_nxt = (rin_direct_r[amr_pkg::F_BYP_GAIN_MSB:
                               amr_pkg::F_BYP_GAIN_LSB]
                  != amr_pkg::GAIN_MUTE)
      || lout_route_r[amr_pkg::F_OTHER_L2N]
      || lout_route_r[amr_pkg::F_SAME_L2N]
      || lout_route_r[amr_pkg::F_SAME_L2P]
      || rout_route_r[amr_pkg::F_OTHER_L2N]
      || rout_route_r[amr_pkg::F_SAME_L2N]
      || rout_route_r[amr_pkg::F_SAME_L2P];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      needed_r <= 1'b0;
      missing_r <= 1'b0;
    end else if (pclk_en) begin
      needed_r <= needed_nxt;
      missing_r <= needed_nxt && !mix_ctrl_r[amr_pkg::F_MIDRAIL_EN];
    end
  end

  always_comb begin
    status_w = 16'h0000;
    status_w[amr_pkg::F_ST_NEEDED] = needed_r;
    status_w[amr_pkg::F_ST_MISSING] = missing_r;
  end

  // Bus outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Input mixer gains and control
  assign right_bypass_gain = rin_direct_r[amr_pkg::F_BYP_GAIN_MSB:
                                          amr_pkg::F_BYP_GAIN_LSB];
  assign rx_voice_right_gain = rin_direct_r[amr_pkg::F_RXV_GAIN_MSB:
                                            amr_pkg::F_RXV_GAIN_LSB];
  assign right_bypass_boost = mix_ctrl_r[amr_pkg::F_BOOST];
  assign midrail_buffer_enable = mix_ctrl_r[amr_pkg::F_MIDRAIL_EN];
  assign right_bypass_db = byp_db_r;
  assign right_bypass_muted = byp_muted_r;
  assign rx_voice_right_db = rxv_db_r;
  assign rx_voice_right_muted = rxv_muted_r;

  // Left output mixer; a one unmutes each path
  assign left_phones_source_sel = lout_route_r[amr_pkg::F_PHONES_SEL];
  assign rin_mix_to_lout_mix_on = lout_route_r[amr_pkg::F_CROSS_MIX];
  assign lin_mix_to_lout_mix_on = lout_route_r[amr_pkg::F_SAME_MIX];
  assign r_line2_neg_to_lout_on = lout_route_r[amr_pkg::F_OTHER_L2N];
  assign l_line2_neg_to_lout_on = lout_route_r[amr_pkg::F_SAME_L2N];
  assign r_amp1_to_lout_on = lout_route_r[amr_pkg::F_OTHER_AMP1];
  assign l_amp1_to_lout_on = lout_route_r[amr_pkg::F_SAME_AMP1];
  assign l_line2_pos_to_lout_on = lout_route_r[amr_pkg::F_SAME_L2P];
  assign left_dac_to_lout_on = lout_route_r[amr_pkg::F_DAC];

  // Right output mixer; mirror image of the left one
  assign right_phones_source_sel = rout_route_r[amr_pkg::F_PHONES_SEL];
  assign lin_mix_to_rout_mix_on = rout_route_r[amr_pkg::F_CROSS_MIX];
  assign rin_mix_to_rout_mix_on = rout_route_r[amr_pkg::F_SAME_MIX];
  assign l_line2_neg_to_rout_on = rout_route_r[amr_pkg::F_OTHER_L2N];
  assign r_line2_neg_to_rout_on = rout_route_r[amr_pkg::F_SAME_L2N];
  assign l_amp1_to_rout_on = rout_route_r[amr_pkg::F_OTHER_AMP1];
  assign r_amp1_to_rout_on = rout_route_r[amr_pkg::F_SAME_AMP1];
  assign r_line2_pos_to_rout_on = rout_route_r[amr_pkg::F_SAME_L2P];
  assign right_dac_to_rout_on = rout_route_r[amr_pkg::F_DAC];

  // Midrail status
  assign midrail_needed = needed_r;
  assign midrail_missing = missing_r;

endmodule : amr_regs

// ==== amr_regs_asserts.sv ====
// Checker for the mixer routing register bank, bound onto amr_regs.
// Assumes one clock; pclk_en is qualified where a result depends on it.
`timescale 1ns/1ps
module amr_regs_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Fields
  input wire logic [2:0] right_bypass_gain,
  input wire logic [2:0] rx_voice_right_gain,
  input wire logic right_bypass_boost,
  input wire logic signed [4:0] right_bypass_db,
  input wire logic signed [4:0] rx_voice_right_db,
  input wire logic rx_voice_right_muted,
  input wire logic left_phones_source_sel,
  input wire logic right_phones_source_sel
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Both lanes needed, else a field may keep half its old bits
  wire logic wr_done = psel & penable & pready & pwrite & pclk_en
    & (pstrb[1:0] == 2'b11);
  sequence s_setup;
    psel && !penable && pclk_en;
  endsequence
  sequence s_wr(logic [11:0] a);
    wr_done && paddr == a;
  endsequence
  chk_setup_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready && pclk_en |=> !pready)
    else $error("ready held too long");
  chk_unmapped_err: assert property (s_setup ##0 paddr == 12'h0C0
    |=> pready && pslverr) else $error("unmapped access not refused");
  chk_bypass_field: assert property (
    s_wr(12'hB0) |=> right_bypass_gain == $past(pwdata[8:6]))
    else $error("bypass gain not stored");
  chk_voice_field: assert property (
    s_wr(12'hB0) |=> rx_voice_right_gain == $past(pwdata[2:0]))
    else $error("voice gain not stored");
  chk_left_sel: assert property (
    s_wr(12'hB4) |=> left_phones_source_sel == $past(pwdata[8]))
    else $error("left phones select not stored");
  chk_right_sel: assert property (
    s_wr(12'hB8) |=> right_phones_source_sel == $past(pwdata[8]))
    else $error("right phones select not stored");
  chk_boost_top: assert property (
    right_bypass_gain == 3'h7 && right_bypass_boost && pclk_en
    |=> right_bypass_db == 5'sd15) else $error("boosted top wrong");
  chk_bypass_steps: assert property (
    right_bypass_gain != 3'h0 && pclk_en
    && !(right_bypass_gain == 3'h7 && right_bypass_boost)
    |=> right_bypass_db == 5'(3 * $past(right_bypass_gain) - 15))
    else $error("bypass step wrong");
  chk_voice_mute: assert property (
    rx_voice_right_gain == 3'h0 && pclk_en
    |=> rx_voice_right_muted && rx_voice_right_db == 5'sd0)
    else $error("voice mute wrong");
  chk_voice_top: assert property (
    rx_voice_right_gain == 3'h7 && pclk_en |=> rx_voice_right_db == 5'sd6)
    else $error("voice top wrong");
  chk_upper_zero: assert property (
    pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule : amr_regs_asserts

// ==== amr_regs_tb.sv ====
// Self-checking bench for the mixer routing register bank.
// Assumes the package, gain decoder and checker are compiled first.
`timescale 1ns/1ps
module amr_regs_tb;
  logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd;
  logic [3:0] pstrb;
  logic [2:0] right_bypass_gain, rx_voice_right_gain;
  logic right_bypass_boost, midrail_buffer_enable, er;
  logic signed [4:0] right_bypass_db, rx_voice_right_db;
  logic right_bypass_muted, rx_voice_right_muted;
  logic left_phones_source_sel, rin_mix_to_lout_mix_on;
  logic lin_mix_to_lout_mix_on, r_line2_neg_to_lout_on;
  logic l_line2_neg_to_lout_on, r_amp1_to_lout_on, l_amp1_to_lout_on;
  logic l_line2_pos_to_lout_on, left_dac_to_lout_on;
  logic right_phones_source_sel, lin_mix_to_rout_mix_on;
  logic rin_mix_to_rout_mix_on, l_line2_neg_to_rout_on;
  logic r_line2_neg_to_rout_on, l_amp1_to_rout_on, r_amp1_to_rout_on;
  logic r_line2_pos_to_rout_on, right_dac_to_rout_on;
  logic midrail_needed, midrail_missing;
  logic [11:0] adr [4] = '{12'hB0, 12'hB4, 12'hB8, 12'h100};
  int err_total, comparisons;
  wire logic [8:0] lout = {left_phones_source_sel, rin_mix_to_lout_mix_on,
    lin_mix_to_lout_mix_on, r_line2_neg_to_lout_on, l_line2_neg_to_lout_on,
    r_amp1_to_lout_on, l_amp1_to_lout_on, l_line2_pos_to_lout_on,
    left_dac_to_lout_on};
  wire logic [8:0] rout = {right_phones_source_sel, lin_mix_to_rout_mix_on,
    rin_mix_to_rout_mix_on, l_line2_neg_to_rout_on, r_line2_neg_to_rout_on,
    l_amp1_to_rout_on, r_amp1_to_rout_on, r_line2_pos_to_rout_on,
    right_dac_to_rout_on};
  amr_regs amr_regs_i (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic signed [4:0] exp_db(input logic [2:0] c,
    input logic b);
    if (c == 3'h0) return 5'sd0;
    if (c == 3'h7 && b) return 5'sd15;
    return 5'(3 * c - 15);
  endfunction : exp_db
  function automatic logic [15:0] msk(input logic [11:0] a);
    if (a == 12'hB0) return 16'h01C7;
    return (a == 12'h100) ? 16'h0003 : 16'h01FF;
  endfunction : msk
  task automatic check(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic print_verdict;
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // One idle edge first, so psel is never assigned twice in a step
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      err_total++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, pclk_en, psel, penable, pwrite, pstrb} = '0;
    {paddr, pwdata, err_total, comparisons} = '0;
    seed = 32'h63565D36;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    pclk_en <= 1'b1;
    foreach (adr[i]) begin
      apb(1'b0, adr[i], '0, 4'h0);
      check("reset", rd, 32'h0);
    end
    repeat (40) begin
      seed = xs(seed);
      apb(1'b1, adr[seed[31:30]], seed, 4'hF);
      apb(1'b0, paddr, '0, 4'h0);
      check("readback", rd, {16'h0, seed[15:0] & msk(paddr)});
    end
    // Walking one exposes any swapped routing bit
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, 12'hB4, 32'h1 << i, 4'hF);
      apb(1'b1, 12'hB8, 32'h1 << i, 4'hF);
      // The last write lands on the edge the task returns at
      @(posedge pclk);
      check("lout", lout, 9'h1 << i);
      check("rout", rout, 9'h1 << i);
    end
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, 12'h100, b, 4'hF);
        apb(1'b1, 12'hB0, (c << 6) | c, 4'hF);
        repeat (2) @(posedge pclk);
        check("bypass", right_bypass_gain, c);
        check("voice", rx_voice_right_gain, c);
        check("bypass_db", right_bypass_db, exp_db(c, b));
        check("voice_db", rx_voice_right_db, exp_db(c, 1'b0));
        check("muted", {right_bypass_muted, rx_voice_right_muted},
          {2{c == 0}});
        check("boost", right_bypass_boost, b);
      end
    end
    apb(1'b0, 12'h104, '0, 4'h0);
    check("status", rd, 32'h3);
    check("flags", {midrail_needed, midrail_missing}, 2'h3);
    apb(1'b1, 12'h100, 32'h2, 4'hF);
    apb(1'b0, 12'h104, '0, 4'h0);
    check("status", rd, 32'h1);
    check("flags", {midrail_needed, midrail_missing}, 2'h2);
    check("buf_en", midrail_buffer_enable, 1'b1);
    apb(1'b1, 12'h0C0, 32'hFFFF, 4'hF);
    check("err", er, 1'b1);
    apb(1'b0, 12'h0C0, '0, 4'h0);
    check("unmapped_err", er, 1'b1);
    check("unmapped", rd, 32'h0);
    apb(1'b1, 12'hB4, 32'h0, 4'hF);
    apb(1'b1, 12'hB4, 32'h1FF, 4'h1);
    @(posedge pclk);
    check("lane", lout, 9'h0FF);
    // Reset in mid-run must clear the routing again
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'hB4, '0, 4'h0);
    check("rereset", rd, 32'h0);
    print_verdict();
  end
endmodule : amr_regs_tb
bind amr_regs amr_regs_asserts amr_regs_asserts_i (.*);
